/* hsc_ctrl.v */
// Dual hot-swap channel sequencing and fault logic.
`timescale 1ns/1ps
`default_nettype none
`include "hsc_regs.vh"
module hsc_ctrl #(
  parameter [31:0] STARTUP_CYC = `HSC_STARTUP_CYC,
  parameter [31:0] RETRY_CYC = `HSC_RETRY_CYC
) (
  // Clock and reset
  input wire core_clk,
  input wire rst,
  // Address straps: {high, low} per pin, open when both clear
  input wire [1:0] addr_select_0,
  input wire [1:0] addr_select_1,
  input wire [1:0] addr_select_2,
  // Board-present and coupling pins
  input wire board_present_n_1,
  input wire board_present_n_2,
  input wire couple_independent,
  // On-request pins
  input wire channel_on_request_1,
  input wire channel_on_request_2,
  // Comparators per channel, bit 0 is channel 1
  input wire [1:0] overvoltage_input,
  input wire [1:0] undervoltage_input,
  input wire [1:0] undervoltage_reset,
  input wire [1:0] output_feedback,
  input wire [1:0] overcurrent,
  input wire [1:0] current_limiting,
  input wire timer_internal,
  input wire timer_expired,
  input wire cooldown_done,
  // Host control, written from the serial slave
  input wire [1:0] host_swon_set,
  input wire [1:0] host_swon_clr,
  input wire [7:0] ctrl_wdata,
  input wire [1:0] ctrl_we,
  input wire [4:0] alert_en_1,
  input wire [4:0] alert_en_2,
  // Outputs
  output reg [6:0] bus_addr,
  output reg pass_gate_drive_1,
  output reg pass_gate_drive_2,
  output reg [1:0] foldback_en,
  output reg [1:0] gpio_out,
  output reg [1:0] gpio_oe,
  output reg alert_out,
  output reg alert_oe,
  output reg [4:0] fault_log_1,
  output reg [4:0] fault_log_2,
  output reg [7:0] ctrl_1,
  output reg [7:0] ctrl_2
);

  // ==================================================
  // Input synchronisers
  localparam NS = 20;
  wire [NS-1:0] raw = {couple_independent, timer_internal, cooldown_done,
    timer_expired, current_limiting, overcurrent, output_feedback,
    undervoltage_reset, undervoltage_input, overvoltage_input,
    channel_on_request_2, channel_on_request_1,
    board_present_n_2, board_present_n_1};
  reg [NS-1:0] s1;
  reg [NS-1:0] s2;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      // Presence bits start at their pulled-up idle level: no false edge.
      s1 <= {{(NS-2){1'b0}}, 2'b11};
      s2 <= {{(NS-2){1'b0}}, 2'b11};
    end else begin
      s1 <= raw;
      s2 <= s1;
    end
  end
  wire [1:0] bp_n = s2[1:0];
  wire [1:0] onr = s2[3:2];
  wire [1:0] ov = s2[5:4];
  wire [1:0] uv = s2[7:6];
  wire [1:0] uvr = s2[9:8];
  wire [1:0] fb = s2[11:10];
  wire [1:0] oc = s2[13:12];
  wire [1:0] clim = s2[15:14];
  wire tmr_exp = s2[16];
  wire cool_ok = s2[17];
  wire timer_internal_q = s2[18];
  wire indep = s2[19];
  reg [1:0] bp_d;
  reg [1:0] onr_d;
  reg prime;
  // ==================================================
  // Sequencer states
  localparam ST_WAIT = 3'd0;
  localparam ST_DEB = 3'd1;
  localparam ST_RDY = 3'd2;
  localparam ST_START = 3'd3;
  localparam ST_ON = 3'd4;
  localparam ST_COOL = 3'd5;
  reg [2:0] st [0:1];
  reg [31:0] cnt [0:1];
  reg [31:0] ocnt [0:1];
  reg [4:0] flog [0:1];
  reg [7:0] ctl [0:1];
  wire [1:0] in_range = ~ov & uv;
  wire [1:0] ok = in_range & ~bp_n;
  wire [1:0] in_start = {st[1] == ST_START, st[0] == ST_START};
  wire [1:0] rdy = {st[1] == ST_RDY, st[0] == ST_RDY};
  wire [1:0] gate_on = {st[1] >= ST_START && st[1] <= ST_ON,
    st[0] >= ST_START && st[0] <= ST_ON};
  wire [1:0] swon = {ctl[1][`HSC_C_SWON], ctl[0][`HSC_C_SWON]};
  wire [1:0] bp_fall = bp_d & ~bp_n;
  wire [1:0] on_fall = onr_d & ~onr;
  wire [1:0] on_rise = ~onr_d & onr;
  wire [1:0] trip_ov = ov & gate_on;
  wire [1:0] trip_uv = ~uv & gate_on;
  wire [1:0] trip_cb = {oc[1] && st[1] == ST_ON &&
      ocnt[1] >= `HSC_BREAKER_CYC - 1,
    oc[0] && st[0] == ST_ON && ocnt[0] >= `HSC_BREAKER_CYC - 1};
  wire [1:0] st_exp = {in_start[1] && (timer_internal_q ?
      cnt[1] >= STARTUP_CYC - 1 : tmr_exp),
    in_start[0] && (timer_internal_q ? cnt[0] >= STARTUP_CYC - 1 : tmr_exp)};
  wire [1:0] trip_oc = st_exp & clim;
  wire [1:0] pbad = ~fb & gate_on & ~in_start;
  wire [1:0] own_off = trip_ov | trip_uv | trip_cb | trip_oc | pbad
    | (bp_n & gate_on) | (~swon & gate_on);
  wire [1:0] off = indep ? own_off : {2{|own_off}};
  wire [1:0] go = indep ?
    {rdy[1] & swon[1] & ~in_start[0], rdy[0] & swon[0] & ~in_start[1]} :
    {2{&rdy & &swon}};

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : ch
      // Per-channel sequencer, fault log and control register.
      always @(posedge core_clk or posedge rst) begin
        if (rst) begin
          st[g] <= ST_WAIT;
          cnt[g] <= 32'h0000_0000;
          ocnt[g] <= 32'h0000_0000;
          flog[g] <= 5'h0_0;
          ctl[g] <= `HSC_CTRL_RST;
        end else begin
          ocnt[g] <= oc[g] ? ocnt[g] + 32'h0000_0001 : 32'h0000_0000;
          // Host writes first; pin events below take priority.
          if (ctrl_we[g])
            ctl[g] <= ctrl_wdata;
          if (host_swon_set[g])
            ctl[g][`HSC_C_SWON] <= 1'b1;
          if (host_swon_clr[g])
            ctl[g][`HSC_C_SWON] <= 1'b0;
          if (prime && on_rise[g])
            ctl[g][`HSC_C_SWON] <= 1'b1;
          if (prime && on_fall[g])
            ctl[g][`HSC_C_SWON] <= 1'b0;
          if (prime && bp_fall[g])
            ctl[g][`HSC_C_SWON] <= onr[g];
          // Fault clears happen first so a same-cycle event is kept.
          // reset-level clear
          if (uvr[g])
            flog[g] <= flog[g] & (5'h0_1 << `HSC_F_UV);
          else if (prime && (on_fall[g] || bp_fall[g]))
            flog[g] <= 5'h0_0;
          if (bp_d[g] != bp_n[g])
            flog[g][`HSC_F_BP] <= 1'b1;
          if (trip_ov[g])
            flog[g][`HSC_F_OV] <= 1'b1;
          if (trip_uv[g])
            flog[g][`HSC_F_UV] <= 1'b1;
          if (trip_cb[g] || trip_oc[g])
            flog[g][`HSC_F_OC] <= 1'b1;
          if (pbad[g])
            flog[g][`HSC_F_PB] <= 1'b1;
          case (st[g])
            ST_WAIT: begin
              cnt[g] <= 32'h0000_0000;
              if (ok[g])
                st[g] <= ST_DEB;
            end
            ST_DEB: begin
              if (!ok[g]) begin
                st[g] <= ST_WAIT;
              end else if (cnt[g] >= STARTUP_CYC - 1) begin
                st[g] <= ST_RDY;
                cnt[g] <= 32'h0000_0000;
                if (!prime)
                  ctl[g][`HSC_C_SWON] <= onr[g];
              end else begin
                cnt[g] <= cnt[g] + 32'h0000_0001;
              end
            end
            ST_RDY: begin
              if (!ok[g])
                st[g] <= ST_WAIT;
              else if (go[g])
                st[g] <= ST_START;
            end
            ST_START: begin
              cnt[g] <= cnt[g] + 32'h0000_0001;
              if (off[g])
                st[g] <= (trip_cb[g] | trip_oc[g]) ? ST_COOL : ST_WAIT;
              else if (st_exp[g])
                st[g] <= trip_oc[g] ? ST_COOL : ST_ON;
            end
            ST_ON: begin
              cnt[g] <= 32'h0000_0000;
              if (off[g])
                st[g] <= trip_cb[g] ? ST_COOL : ST_WAIT;
            end
            ST_COOL: begin
              cnt[g] <= cnt[g] + 32'h0000_0001;
              if (timer_internal_q ? cnt[g] >= RETRY_CYC - 1 : cool_ok) begin
                st[g] <= ST_WAIT;
                if (!ctl[g][`HSC_C_RETRY])
                  ctl[g][`HSC_C_SWON] <= 1'b0;
              end
            end
            default: st[g] <= ST_WAIT;
          endcase
        end
      end
    end
  endgenerate

  // ==================================================
  // Edge history and output registers
  // tri-level address decode
  function [1:0] tri3;
    input [1:0] p;
    begin
      tri3 = p[1] ? 2'd2 : (p[0] ? 2'd0 : 2'd1);
    end
  endfunction
  wire [6:0] adr_ofs = {2'b00, 5'd9 * {3'b000, tri3(addr_select_2)}
    + 5'd3 * {3'b000, tri3(addr_select_1)} + {3'b000, tri3(addr_select_0)}};
  wire [4:0] ae [0:1];
  assign ae[0] = alert_en_1;
  assign ae[1] = alert_en_2;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bp_d <= 2'b11;
      onr_d <= 2'b00;
      prime <= 1'b0;
      bus_addr <= `HSC_ADDR_BASE;
      pass_gate_drive_1 <= 1'b0;
      pass_gate_drive_2 <= 1'b0;
      foldback_en <= 2'b00;
      gpio_out <= 2'b00;
      gpio_oe <= 2'b11;
      alert_out <= 1'b0;
      alert_oe <= 1'b0;
      fault_log_1 <= 5'h0_0;
      fault_log_2 <= 5'h0_0;
      ctrl_1 <= `HSC_CTRL_RST;
      ctrl_2 <= `HSC_CTRL_RST;
    end else begin
      bp_d <= bp_n;
      onr_d <= onr;
      // Switch-on and log-clear edges are ignored until the first debounce done, to avoid sync noise.
      prime <= prime | rdy[0] | rdy[1];
      bus_addr <= `HSC_ADDR_BASE + adr_ofs;
      pass_gate_drive_1 <= gate_on[0] & ~off[0];
      pass_gate_drive_2 <= gate_on[1] & ~off[1];
      foldback_en <= in_start;
      gpio_out <= 2'b00;
      gpio_oe <= {~fb[1] & ctl[1][`HSC_C_GP_LO] & ~ctl[1][`HSC_C_GP_HI],
        ~fb[0] & ctl[0][`HSC_C_GP_LO] & ~ctl[0][`HSC_C_GP_HI]};
      alert_out <= 1'b0;
      alert_oe <= |(flog[0] & ae[0]) | |(flog[1] & ae[1]);
      fault_log_1 <= flog[0];
      fault_log_2 <= flog[1];
      ctrl_1 <= ctl[0];
      ctrl_2 <= ctl[1];
    end
  end

endmodule // hsc_ctrl
`default_nettype wire

/* hsc_ctrl_chk.sv */
// Assertion checker bound to the hot-swap channel controller.
`timescale 1ns/1ps
`default_nettype none
`include "hsc_regs.vh"
// ==========================================
// Checker
module hsc_ctrl_chk #(
  parameter [31:0] STARTUP_CYC = 32'd20
) (
  // Clock, reset and pins
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [1:0] addr_select_0,
  input wire logic [1:0] addr_select_1,
  input wire logic [1:0] addr_select_2,
  input wire logic board_present_n_1,
  input wire logic couple_independent,
  input wire logic [1:0] overvoltage_input,
  input wire logic [1:0] undervoltage_input,
  input wire logic [4:0] alert_en_1,
  input wire logic [4:0] alert_en_2,
  // Outputs under watch
  input wire logic [6:0] bus_addr,
  input wire logic pass_gate_drive_1,
  input wire logic pass_gate_drive_2,
  input wire logic [1:0] foldback_en,
  input wire logic [1:0] gpio_oe,
  input wire logic alert_oe,
  input wire logic [4:0] fault_log_1,
  input wire logic [4:0] fault_log_2,
  input wire logic [7:0] ctrl_1
);
  reg [31:0] fb_cnt;
  wire hit = |(fault_log_1 & alert_en_1) || |(fault_log_2 & alert_en_2);
  function automatic [1:0] lvl(input logic [1:0] p);
    lvl = p[1] ? 2'd2 : (p[0] ? 2'd0 : 2'd1);
  endfunction
  // Expected address; an open strap counts as the middle level.
  wire [6:0] exp_addr = 7'h40 + 7'd9 * lvl(addr_select_2)
    + 7'd3 * lvl(addr_select_1) + lvl(addr_select_0);
  // Foldback run length; a stuck foldback would keep current low forever.
  always @(posedge core_clk or posedge rst)
    if (rst) fb_cnt <= 32'h0;
    else fb_cnt <= foldback_en[0] ? fb_cnt + 32'h1 : 32'h0;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_ov_held; overvoltage_input[0] [*8]; endsequence
  sequence s_uv_low; (!undervoltage_input[1]) [*8]; endsequence
  sequence s_alert_due; hit [*3]; endsequence
  sequence s_alert_idle; (!hit) [*3]; endsequence
  a_addr_decode:
    assert property ($stable({addr_select_2, addr_select_1, addr_select_0})
      [*4] |-> bus_addr == exp_addr) else $error("address decode wrong");
  a_reset_state:
    assert property (disable iff (1'b0) rst && $past(rst) |->
      gpio_oe == 2'b11 &&
      fault_log_1 == 5'h0 && !pass_gate_drive_1 &&
      ctrl_1 == `HSC_CTRL_RST) else $error("reset state wrong");
  a_present_block:
    assert property (board_present_n_1 [*8] |-> !pass_gate_drive_1)
    else $error("gate on without board");
  a_ov_trip:
    assert property (s_ov_held |-> !pass_gate_drive_1 &&
      fault_log_1[`HSC_F_OV]) else $error("overvoltage not handled");
  a_uv_trip:
    assert property (s_uv_low |-> !pass_gate_drive_2 &&
      fault_log_2[`HSC_F_UV]) else $error("undervoltage not handled");
  a_alert_due:
    assert property (s_alert_due |-> alert_oe) else $error("alert missing");
  a_alert_mask:
    assert property (s_alert_idle |-> !alert_oe) else $error("alert stray");
  a_coupled_pair:
    assert property ((!couple_independent) [*8] |->
      pass_gate_drive_1 == pass_gate_drive_2) else $error("pair split");
  a_fold_bound:
    assert property (fb_cnt <= STARTUP_CYC + 32'd4)
    else $error("foldback too long");
endmodule // hsc_ctrl_chk
bind hsc_ctrl hsc_ctrl_chk #(.STARTUP_CYC(STARTUP_CYC)) hsc_ctrl_chk_inst (
  .core_clk(core_clk), .rst(rst), .addr_select_0(addr_select_0),
  .addr_select_1(addr_select_1), .addr_select_2(addr_select_2),
  .board_present_n_1(board_present_n_1),
  .couple_independent(couple_independent),
  .overvoltage_input(overvoltage_input),
  .undervoltage_input(undervoltage_input), .alert_en_1(alert_en_1),
  .alert_en_2(alert_en_2), .bus_addr(bus_addr),
  .pass_gate_drive_1(pass_gate_drive_1),
  .pass_gate_drive_2(pass_gate_drive_2), .foldback_en(foldback_en),
  .gpio_oe(gpio_oe), .alert_oe(alert_oe), .fault_log_1(fault_log_1),
  .fault_log_2(fault_log_2), .ctrl_1(ctrl_1));
`default_nettype wire

/* hsc_fet_model.sv */
// Behavioural model of the two external pass switches and their loads.
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Pass switch and load model
module hsc_fet_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Gate drives from the controller
  input wire logic [1:0] gate,
  // Load status back to the controller
  output logic [1:0] output_feedback,
  output logic [1:0] current_limiting
);
  logic [3:0] age [0:1];
  // Cycles since each gate came on; the load needs time to charge.
  always @(posedge core_clk or posedge rst) begin
    for (int k = 0; k < 2; k++) begin
      if (rst || !gate[k]) age[k] <= 4'h0;
      else if (age[k] != 4'hF) age[k] <= age[k] + 4'h1;
    end
  end
  // Inrush is limited briefly, so start-up expiry logs no overcurrent.
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      current_limiting[k] = gate[k] && age[k] < 4'h5;
      output_feedback[k] = age[k] >= 4'h8;
    end
  end
endmodule // hsc_fet_model
`default_nettype wire

/* hsc_regs.vh */
// Constants for the dual hot-swap channel control block.
// Operation
// - Decode three tri-level address pins into one of 27 bus addresses.
// - Pull alert low when a logged fault has its alert enable set.
// - Coupling low: channels start together; any fault or off stops both.
// - Coupling high: each channel starts and stops on its own.
// - Coupling high: each channel waits while the other is in start-up.
// - Gate may turn on only while board-present input is low.
// - Every board-present transition is logged in the channel fault log.
// - Board-present falling edge samples on-request and clears faults.
// - Power bad drives general-purpose pin low or releases it per bits 6, 7.
// - Power-bad fault logged only when feedback low, start-up done, gate on.
// - Foldback active only in start-up; afterwards raised current limit selected.
// - After reset general-purpose pins pull low to signal power not good.
// - On-request rising edge turns gate on, falling edge turns it off.
// - On-request high at power-up sets switch-on bit after 100ms.
// - On-request low at power-up keeps channel off until host sets bit.
// - On-request falling edge clears only that channel's fault log.
// - Overvoltage trip logs a fault and turns the gate off.
// - Breaker armed after start-up; trips after 20us continuous overcurrent.
// - Start-up timer expiry while current limited logs overcurrent fault.
// - Timer pin on internal supply: 100ms start-up, 5 s retry off time.
// - Undervoltage trip logs a fault and turns the gate off.
// - Undervoltage input below reset level clears log except undervoltage bit.
// - Start conditions must hold 100ms before turn-on.
// - Reset clears fault logs and sets control to defined states.
// - After breaker trip wait for cool-down, retry only if auto-retry enabled.
`ifndef HSC_REGS_VH
`define HSC_REGS_VH
// ==================================================
// Timing
`define HSC_CLK_HZ 125000000
`define HSC_STARTUP_MS 100
`define HSC_STARTUP_CYC ((`HSC_CLK_HZ / 1000) * `HSC_STARTUP_MS)
`define HSC_RETRY_S 5
`define HSC_RETRY_CYC (`HSC_CLK_HZ * `HSC_RETRY_S)
`define HSC_BREAKER_NS 20000
`define HSC_BREAKER_CYC ((`HSC_CLK_HZ / 1000000) * `HSC_BREAKER_NS / 1000)
// ==================================================
// Fault log fields
`define HSC_F_OV 0
`define HSC_F_UV 1
`define HSC_F_OC 2
`define HSC_F_PB 3
`define HSC_F_BP 4
// ==================================================
// Control fields and reset value
`define HSC_C_RETRY 2
`define HSC_C_SWON 3
`define HSC_C_GP_LO 6
`define HSC_C_GP_HI 7
`define HSC_CTRL_RST 8'h40
// Fixed bus address base, decoded offset added
`define HSC_ADDR_BASE 7'h4_0
`endif

/* tb_hsc_ctrl.sv */
// Self-checking testbench for the hot-swap channel controller.
`timescale 1ns/1ps
`default_nettype none
`include "hsc_regs.vh"
// ==========================================
// Testbench
module tb_hsc_ctrl;
  localparam int SU = 20;
  logic core_clk = 0;
  logic rst = 1;
  logic [1:0] a0 = 2'b01, a1 = 2'b01, a2 = 2'b01;
  logic bp1_n = 1, bp2_n = 1, ind = 1, on1 = 1, on2 = 0;
  logic [1:0] ov = 0, uv = 2'b11, uvr = 0, oc = 0, swon = 0, swclr = 0;
  logic [4:0] en1 = 5'h01, en2 = 5'h0;
  logic [7:0] wd = 8'h00;
  logic [1:0] we = 2'b00;
  logic [31:0] seed = 32'h8;
  int n_fail = 0, tests_run = 0, cyc = 0;
  wire [1:0] fb, lim, fold, gout, goe;
  wire [6:0] addr;
  wire g1, g2, aout, aoe;
  wire [4:0] log1, log2;
  wire [7:0] c1, c2;
  hsc_ctrl #(.STARTUP_CYC(SU), .RETRY_CYC(40)) hsc_ctrl_inst (
    .core_clk(core_clk), .rst(rst), .addr_select_0(a0),
    .addr_select_1(a1), .addr_select_2(a2), .board_present_n_1(bp1_n),
    .board_present_n_2(bp2_n), .couple_independent(ind),
    .channel_on_request_1(on1), .channel_on_request_2(on2),
    .overvoltage_input(ov), .undervoltage_input(uv),
    .undervoltage_reset(uvr), .output_feedback(fb), .overcurrent(oc),
    .current_limiting(lim), .timer_internal(1'b1), .timer_expired(1'b0),
    .cooldown_done(1'b0), .host_swon_set(swon), .host_swon_clr(swclr),
    .ctrl_wdata(wd), .ctrl_we(we), .alert_en_1(en1),
    .alert_en_2(en2), .bus_addr(addr), .pass_gate_drive_1(g1),
    .pass_gate_drive_2(g2), .foldback_en(fold), .gpio_out(gout),
    .gpio_oe(goe), .alert_out(aout), .alert_oe(aoe), .fault_log_1(log1),
    .fault_log_2(log2), .ctrl_1(c1), .ctrl_2(c2));
  hsc_fet_model hsc_fet_model_inst (.core_clk(core_clk), .rst(rst),
    .gate({g2, g1}), .output_feedback(fb), .current_limiting(lim));
  // Clock, 8 ns period.
  always #4 core_clk = ~core_clk;
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic done(input string s);
    $display("Test %s finished", s);
  endtask
  // Bounded wait for a gate level; a hang falls through to the compare.
  task automatic wait_for(input int ch, input logic v);
    for (int i = 0; i < 300; i++) begin
      if ((ch == 1 ? g1 : g2) === v) break;
      tick(1);
    end
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [1:0] strap(input int v);
    return v == 0 ? 2'b01 : (v == 1 ? 2'b00 : 2'b10);
  endfunction
  // Cycle ceiling so a stuck run still reaches the verdict.
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      $display("FAIL at %0t: cycles %h limit %h", $time, cyc, 40000);
      stop_test();
    end
  end
  // Main sequence; inputs change only at the falling edge.
  initial begin
    tick(20);
    chk({c1, goe}, {`HSC_CTRL_RST, 2'b11});
    rst = 0;
    for (int k = 0; k < 27; k++) begin
      a0 = strap(k % 3);
      a1 = strap(k / 3 % 3);
      a2 = strap(k / 9);
      tick(6);
      chk(addr, 7'h40 + k);
    end
    done("address");
    bp1_n = 0;
    bp2_n = 0;
    tick(SU - 4);
    chk(g1, 0);
    wait_for(1, 1);
    chk({c1[`HSC_C_SWON], log1[`HSC_F_BP]}, 2'b11);
    tick(60);
    chk(g2, 0);
    swon = 2'b10;
    tick(1);
    swon = 0;
    wait_for(2, 1);
    chk(fold, 2'b10);
    tick(SU + 4);
    chk(fold, 2'b00);
    done("start-up");
    for (int k = 0; k < 8; k++) begin
      seed = xs(seed);
      oc = 2'b01;
      tick(seed[10:0] + 1);
      oc = 0;
      tick(3);
    end
    chk(g1, 1);
    oc = 2'b01;
    tick(2400);
    chk(g1, 1);
    tick(120);
    chk({g1, g2, log1[`HSC_F_OC]}, 3'b011);
    oc = 0;
    tick(200);
    chk(g1, 0);
    on1 = 0;
    tick(6);
    chk({log1, log2[`HSC_F_BP]}, 6'b000001);
    on1 = 1;
    wait_for(1, 1);
    chk(g1, 1);
    done("breaker");
    ov = 2'b01;
    tick(10);
    chk({g1, g2, log1[`HSC_F_OV], aoe}, 4'b0111);
    ov = 0;
    uv = 2'b10;
    uvr = 2'b01;
    tick(6);
    chk({log1, aoe, goe[0]}, 7'b0000001);
    uvr = 0;
    uv = 2'b01;
    tick(10);
    chk({g2, log2[`HSC_F_UV], goe[1]}, 3'b011);
    uv = 2'b11;
    done("faults");
    on1 = 0;
    swclr = 2'b10;
    tick(1);
    swclr = 0;
    tick(40);
    chk({g1, g2}, 2'b00);
    ind = 0;
    tick(10);
    on1 = 1;
    on2 = 1;
    wait_for(1, 1);
    chk({g1, g2}, 2'b11);
    bp1_n = 1;
    tick(10);
    chk({g1, g2}, 2'b00);
    chk({gout, aout}, 3'b000);
    wd = 8'h44;
    we = 2'b10;
    tick(1);
    we = 2'b00;
    tick(3);
    chk(c2, 8'h44);
    done("coupled");
    stop_test();
  end
endmodule // tb_hsc_ctrl
`default_nettype wire
